// >>> inc/ipbs_pkg.sv
// Constants, register map and state type of the segment buffer sequencer
package ipbs_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int          SEG_DEPTH  = 32;
  localparam int          SEG_BITS   = 24;
  localparam int          MIN_SEGS   = 2;
  localparam int          CTRL_W     = 16;
  localparam int          FREE_W     = 8;
  localparam int          ID_W       = 16;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_SEG    = 8'h00;
  localparam logic [7:0]  OFF_CTRL   = 8'h04;
  localparam logic [7:0]  OFF_STAT   = 8'h08;
  localparam logic [7:0]  OFF_FREE   = 8'h0c;
  localparam logic [7:0]  OFF_TXT    = 8'h10;
  localparam logic [7:0]  OFF_MOVE   = 8'h14;
  // ----------------------------------------------------------------
  // Segment command word fields
  // ----------------------------------------------------------------
  localparam int          HDR_LSB    = 0;
  localparam int          HDR_W      = 8;
  localparam int          HDR_CMD    = 7;
  localparam int          CMD_W      = 7;
  localparam int          ICNT_W     = 3;
  localparam int          ARG_LSB    = 8;
  localparam int          ARG_W      = 8;
  localparam int          SEG_LSB    = 8;
  localparam int          TIME_LSB   = 0;
  localparam int          TIME_W     = 8;
  localparam logic [6:0]  CMD_CLEAR  = 7'h00;
  localparam logic [6:0]  CMD_POP    = 7'h01;
  localparam logic [6:0]  CMD_CLRERR = 7'h02;
  localparam logic [6:0]  CMD_RSTID  = 7'h03;
  // ----------------------------------------------------------------
  // Control word bits, status layout, transmit type
  // ----------------------------------------------------------------
  localparam int          CW_QSTOP   = 2;
  localparam int          CW_START   = 4;
  localparam int          CW_HALT    = 8;
  localparam int          ST_ID_LSB  = 0;
  localparam int          ST_FREE_LSB = 16;
  localparam int          ERR_BASE   = 24;
  localparam int          ERRM_SEQ   = 0;
  localparam int          ERRM_OVF   = 1;
  localparam int          ERRM_UNF   = 2;
  localparam logic [7:0]  TXT_EVENT  = 8'hff;
  localparam logic [7:0]  TXT_RESET  = 8'h00;
  localparam int          MV_ST_LSB  = 0;
  localparam int          MV_RUN     = 2;
  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along idle-run-finish-stop
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IPBS_IDLE   = 2'b00,
    IPBS_RUN    = 2'b01,
    IPBS_FINISH = 2'b11,
    IPBS_STOP   = 2'b10
  } ipbs_state_e;
endpackage

// >>> inc/ipbs_buf_if.sv
// Interface between the sequencer and its segment store
interface ipbs_buf_if #(
  parameter int SEG_W = 24,
  parameter int CNT_W = 6
);
  logic             push;
  logic [SEG_W-1:0] wdata;
  logic             pop;
  logic             drop;
  logic [7:0]       drop_n;
  logic             clear;
  logic [CNT_W-1:0] count;
  logic [SEG_W-1:0] head;
  logic [SEG_W-1:0] next;
  modport owner (output push, wdata, pop, drop, drop_n, clear,
                 input  count, head, next);
  modport store (input  push, wdata, pop, drop, drop_n, clear,
                 output count, head, next);
endinterface

// >>> core/ipbs_seg_buffer.sv
// Circular trajectory segment store with pop of newest entries
module ipbs_seg_buffer #(
  parameter int DEPTH = ipbs_pkg::SEG_DEPTH,
  parameter int SEG_W = ipbs_pkg::SEG_BITS,
  parameter int CNT_W = 6
)(
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  ipbs_buf_if.store bus
);
  import ipbs_pkg::*;
  localparam int PW = $clog2(DEPTH);
  // Pointers wrap naturally, so DEPTH must be a power of two
  logic [SEG_W-1:0] mem [DEPTH];
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    wr_ptr;
  logic [CNT_W-1:0] cnt;
  logic             do_push;
  logic             do_pop;
  logic [CNT_W-1:0] left;
  logic [CNT_W-1:0] n_drop;

  always_comb begin
    do_push = bus.push && (cnt != CNT_W'(DEPTH));
    do_pop  = bus.pop && (cnt != '0);
    left    = cnt - CNT_W'(do_pop);
    n_drop  = '0;
    if (bus.drop) begin
      n_drop = (bus.drop_n > ARG_W'(left)) ? left : CNT_W'(bus.drop_n);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= bus.wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      cnt    <= '0;
    end else if (bus.clear) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      cnt    <= '0;
    end else begin
      rd_ptr <= rd_ptr + PW'(do_pop);
      wr_ptr <= wr_ptr + PW'(do_push) - PW'(n_drop);
      cnt    <= cnt + CNT_W'(do_push) - CNT_W'(do_pop) - n_drop;
    end
  end

  assign bus.count = cnt;
  assign bus.head  = mem[rd_ptr];
  assign bus.next  = mem[rd_ptr + PW'(1)];
endmodule

// >>> core/ipbs_status_tx.sv
// Event driven buffer status send strobe
module ipbs_status_tx (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] tx_type_i,
  input  wire logic       consume_i,
  input  wire logic       error_i,
  output logic            send_o
);
  import ipbs_pkg::*;
  logic pend;

  // Two stages so the strobe meets the status word that shows the event
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend   <= 1'b0;
      send_o <= 1'b0;
    end else begin
      pend   <= (tx_type_i == TXT_EVENT) && (consume_i || error_i);
      send_o <= pend;
    end
  end
endmodule

// >>> core/ipbs_sequencer.sv
// Interpolated move sequencer: segment intake, move control, status
//
// Design decisions made here: the address-and-strobe port and the register offsets.
module ipbs_sequencer #(
  parameter int DEPTH = ipbs_pkg::SEG_DEPTH,
  parameter int SEG_W = ipbs_pkg::SEG_BITS
)(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic             seg_done_i,
  output logic      [31:0]      reg_rdata_o,
  output logic      [SEG_W-1:0] seg_start_o,
  output logic      [SEG_W-1:0] seg_end_o,
  output logic                  interp_run_o,
  output logic                  stop_now_o,
  output logic                  move_done_o,
  output logic      [31:0]      status_o,
  output wire logic             status_send_o
);
  import ipbs_pkg::*;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ipbs_state_e       st;
  logic [CTRL_W-1:0] ctrl;
  logic [7:0]        tx_type;
  logic [ID_W-1:0]   next_id;
  logic              seq_err;
  logic              ovf_err;
  logic              unf_err;

  ipbs_buf_if #(.SEG_W(SEG_W), .CNT_W(CNT_W)) sb ();

  ipbs_seg_buffer #(
    .DEPTH (DEPTH),
    .SEG_W (SEG_W),
    .CNT_W (CNT_W)
  ) u_buf (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .bus       (sb.store)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [HDR_W-1:0]  hdr;
  logic [CMD_W-1:0]  cmd_code;
  logic [ARG_W-1:0]  cmd_arg;
  logic              seg_wr;
  logic              cmd_wr;
  logic              ctrl_wr;
  logic              cnt_ok;
  logic              full;
  logic              seg_acc;
  logic              seq_set;
  logic              ovf_set;
  logic              unf_set;
  logic              do_clear;
  logic              clr_err;
  logic              start_edge;
  logic              start_ok;
  logic              running;
  logic              ctl_abort;
  logic              abort;
  logic              next_zero;
  logic              under;
  logic              pop;
  logic              finish_go;
  logic [FREE_W-1:0] free_cnt;

  assign hdr      = reg_wdata_i[HDR_LSB +: HDR_W];
  assign cmd_code = hdr[CMD_W-1:0];
  assign cmd_arg  = reg_wdata_i[ARG_LSB +: ARG_W];
  assign seg_wr   = reg_wr_i && (reg_addr_i == OFF_SEG) && !hdr[HDR_CMD];
  assign cmd_wr   = reg_wr_i && (reg_addr_i == OFF_SEG) && hdr[HDR_CMD];
  assign ctrl_wr  = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign cnt_ok   = hdr[ICNT_W-1:0] == next_id[ICNT_W-1:0];
  assign full     = sb.count == CNT_W'(DEPTH);

  // A locked intake drops segments silently; no new flag is raised
  assign seg_acc  = seg_wr && !seq_err && cnt_ok && !full;
  assign seq_set  = seg_wr && !seq_err && !cnt_ok;
  assign ovf_set  = seg_wr && !seq_err && cnt_ok && full;
  assign do_clear = cmd_wr && (cmd_code == CMD_CLEAR);
  assign clr_err  = cmd_wr && (cmd_code == CMD_CLRERR);

  assign start_edge = ctrl_wr && reg_wdata_i[CW_START]
                      && !ctrl[CW_START];
  assign start_ok   = reg_wdata_i[CW_QSTOP] && !reg_wdata_i[CW_HALT];
  assign running    = (st == IPBS_RUN) || (st == IPBS_FINISH);
  assign ctl_abort  = !ctrl[CW_START]
                      || !ctrl[CW_QSTOP]
                      || ctrl[CW_HALT];
  assign abort      = running && (ctl_abort || do_clear);
  assign next_zero  = sb.next[TIME_LSB +: TIME_W] == '0;

  // Fewer than two endpoints means the interpolation cannot go on
  assign under = (st == IPBS_RUN)
                 && ((sb.count < CNT_W'(MIN_SEGS))
                     || (seg_done_i && (sb.count == CNT_W'(MIN_SEGS))
                         && !next_zero));
  assign unf_set = under || ((st == IPBS_IDLE) && start_edge && start_ok
                             && (sb.count < CNT_W'(MIN_SEGS)));
  // Second point reached: the first endpoint is released
  assign pop       = seg_done_i && running && !abort;
  assign finish_go = (st == IPBS_RUN) && pop && next_zero && !under;
  assign free_cnt  = FREE_W'(DEPTH) - FREE_W'(sb.count);

  // ----------------------------------------------------------------
  // Buffer requests
  // ----------------------------------------------------------------
  assign sb.push   = seg_acc;
  assign sb.wdata  = reg_wdata_i[SEG_LSB +: SEG_W];
  assign sb.pop    = pop;
  assign sb.drop   = cmd_wr && (cmd_code == CMD_POP);
  assign sb.drop_n = cmd_arg;
  assign sb.clear  = do_clear;

  // ----------------------------------------------------------------
  // Move sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st           <= IPBS_IDLE;
      interp_run_o <= 1'b0;
      stop_now_o   <= 1'b0;
      move_done_o  <= 1'b0;
    end else begin
      stop_now_o  <= 1'b0;
      move_done_o <= 1'b0;
      case (st)
        IPBS_IDLE: begin
          if (start_edge && start_ok
              && (sb.count >= CNT_W'(MIN_SEGS))) begin
            st           <= IPBS_RUN;
            interp_run_o <= 1'b1;
          end
        end
        IPBS_RUN: begin
          if (abort || under) begin
            st           <= IPBS_STOP;
            interp_run_o <= 1'b0;
            stop_now_o   <= 1'b1;
          end else if (finish_go) begin
            st <= IPBS_FINISH;
          end
        end
        IPBS_FINISH: begin
          if (abort) begin
            st           <= IPBS_STOP;
            interp_run_o <= 1'b0;
            stop_now_o   <= 1'b1;
          end else if (seg_done_i) begin
            st           <= IPBS_STOP;
            interp_run_o <= 1'b0;
            move_done_o  <= 1'b1;
          end
        end
        IPBS_STOP: begin
          st <= IPBS_IDLE;
        end
        default: begin
          st           <= IPBS_IDLE;
          interp_run_o <= 1'b0;
        end
      endcase
    end
  end

  // Both endpoints go to the interpolator every cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seg_start_o <= '0;
      seg_end_o   <= '0;
    end else begin
      seg_start_o <= sb.head;
      seg_end_o   <= sb.next;
    end
  end

  // ----------------------------------------------------------------
  // Identifier and error flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      next_id <= '0;
    end else if (cmd_wr && (cmd_code == CMD_RSTID)) begin
      next_id <= '0;
    end else if (seg_acc) begin
      next_id <= next_id + ID_W'(1);
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_err <= 1'b0;
      ovf_err <= 1'b0;
      unf_err <= 1'b0;
    end else begin
      seq_err <= seq_set || (seq_err && !(clr_err && cmd_arg[ERRM_SEQ]));
      ovf_err <= ovf_set || (ovf_err && !(clr_err && cmd_arg[ERRM_OVF]));
      unf_err <= unf_set || (unf_err && !(clr_err && cmd_arg[ERRM_UNF]));
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl    <= '0;
      tx_type <= TXT_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl <= reg_wdata_i[CTRL_W-1:0];
      end
      if (reg_wr_i && (reg_addr_i == OFF_TXT)) begin
        tx_type <= reg_wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o <= '0;
    end else begin
      status_o                          <= '0;
      status_o[ST_ID_LSB +: ID_W]       <= next_id;
      status_o[ST_FREE_LSB +: FREE_W]   <= free_cnt;
      status_o[ERR_BASE + ERRM_SEQ]     <= seq_err;
      status_o[ERR_BASE + ERRM_OVF]     <= ovf_err;
      status_o[ERR_BASE + ERRM_UNF]     <= unf_err;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          OFF_CTRL: reg_rdata_o[CTRL_W-1:0] <= ctrl;
          OFF_STAT: reg_rdata_o <= status_o;
          OFF_FREE: reg_rdata_o[FREE_W-1:0] <= free_cnt;
          OFF_TXT:  reg_rdata_o[7:0] <= tx_type;
          OFF_MOVE: begin
            reg_rdata_o[MV_ST_LSB +: 2] <= st;
            reg_rdata_o[MV_RUN]         <= interp_run_o;
          end
          default:  reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status messages
  // ----------------------------------------------------------------
  ipbs_status_tx u_stx (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .tx_type_i (tx_type),
    .consume_i (pop && (sb.count != '0)),
    .error_i   (seq_set || ovf_set || unf_set),
    .send_o    (status_send_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_min_segs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (st == IPBS_RUN) && $past(st) == IPBS_IDLE
    |-> $past(sb.count) >= CNT_W'(MIN_SEGS))
    else $error("Move started with too few segments");
  chk_start_edge: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (st == IPBS_IDLE) && start_edge && start_ok
    && (sb.count >= CNT_W'(MIN_SEGS)) |=> interp_run_o)
    else $error("Start edge did not start the move");
  chk_bit4_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (st == IPBS_RUN) && !ctrl[CW_START]
    |=> stop_now_o && !interp_run_o ##1 st == IPBS_IDLE)
    else $error("Clearing start bit did not stop");
  chk_qstop_stop: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    running && !ctrl[CW_QSTOP] |=> stop_now_o)
    else $error("Quick stop did not stop");
  chk_halt_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    running && ctrl[CW_HALT] |=> st == IPBS_STOP)
    else $error("Halt did not stop");
  chk_zero_finish: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (st == IPBS_RUN) && pop && next_zero && !under && !ctl_abort
    |=> (st == IPBS_FINISH) && interp_run_o)
    else $error("Zero time segment not finished");
  chk_underflow: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (st == IPBS_RUN) && (sb.count < CNT_W'(MIN_SEGS))
    |=> unf_err && stop_now_o ##2 status_o[ERR_BASE + ERRM_UNF])
    else $error("Underflow not flagged and aborted");
  chk_seq_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_err && seg_wr |=> next_id == $past(next_id))
    else $error("Segment taken while sequence error stands");
  chk_id_advance: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    seg_acc && !pop |=> (next_id == $past(next_id) + ID_W'(1))
    && (free_cnt == $past(free_cnt) - FREE_W'(1)))
    else $error("Accepted segment not counted");
  chk_overflow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    ovf_set |=> ovf_err && $stable(sb.count))
    else $error("Overflow segment not rejected");
  chk_err_clear: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    clr_err && cmd_arg[ERRM_SEQ] |=> !seq_err)
    else $error("Error mask did not clear sequence flag");
  chk_status_send: assert property (@(posedge sys_clk_i)
    disable iff (!rst_b_i)
    (tx_type == TXT_EVENT) && pop && (sb.count != '0)
    |-> ##2 status_send_o)
    else $error("No status sent after consumed segment");
endmodule

// >>> bench/ipbs_interp_model.sv
// Interpolator stand-in that reports each endpoint reached
module ipbs_interp_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic en_i,
  input  wire logic run_i,
  output logic      seg_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gap;
  // Slow pacing leaves room to see every status send between pops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap        <= 3'h0;
      seg_done_o <= 1'b0;
    end else begin
      gap        <= (en_i && run_i) ? gap + 3'h1 : 3'h0;
      seg_done_o <= en_i && run_i && (gap == 3'h7);
    end
  end
endmodule

// >>> bench/ipbs_sequencer_tb_top.sv
// Self-checking bench for the segment buffer sequencer
module ipbs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ipbs_pkg::*;
  typedef struct packed {
    logic [31:0] wd;
    logic [31:0] st;
  } ipbs_row_s;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        en        = 1'b0;
  logic        done;
  logic [31:0] rdata;
  logic [31:0] status;
  logic        run;
  logic        stop;
  logic        mdone;
  logic        send;
  logic [23:0] s_head;
  logic [23:0] s_tail;
  int          fails = 0;
  int          checked = 0;
  int          sends = 0;
  int          stops = 0;
  int          mdones = 0;
  int          n;
  ipbs_row_s   rows [6] = '{'{32'h00aa0500, 32'h001f0001},
    '{32'h00bb0503, 32'h011f0001}, '{32'h00cc0501, 32'h011f0001},
    '{32'h00000182, 32'h001f0001}, '{32'h00cc0501, 32'h001e0002},
    '{32'h00dd0002, 32'h001d0003}};
  logic [31:0] ab [3] = '{32'h00000004, 32'h00000010, 32'h00000114};

  always #4 sys_clk_i = ~sys_clk_i;

  ipbs_interp_model part_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .en_i(en), .run_i(run), .seg_done_o(done));

  ipbs_sequencer dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .seg_done_i(done), .reg_rdata_o(rdata), .seg_start_o(s_head),
    .seg_end_o(s_tail), .interp_run_o(run), .stop_now_o(stop),
    .move_done_o(mdone), .status_o(status), .status_send_o(send));

  // Pulses last one cycle, so count them rather than poll for them
  always @(posedge sys_clk_i) begin
    if (send === 1'b1) sends++;
    if (stop === 1'b1) stops++;
    if (mdone === 1'b1) mdones++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic guard(input int k);
    if (k >= 200) begin
      fails++;
      close_out;
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic settle;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic fresh;
    wreg(OFF_SEG, 32'h00000080);
    wreg(OFF_SEG, 32'h00000083);
    wreg(OFF_CTRL, 32'h0);
  endtask

  initial begin
    #400us;
    fails++;
    close_out;
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    settle;
    check(status, 32'h00200000);
    rreg(OFF_STAT, 32'h00200000);
    rreg(8'h3c, 32'h0);
    wreg(OFF_TXT, 32'h000000ff);
    rreg(OFF_TXT, 32'h000000ff);
    foreach (rows[i]) begin
      wreg(OFF_SEG, rows[i].wd);
      settle;
      check(status, rows[i].st);
    end
    // ----------------------------------------------------------------
    // Full move ended by a zero-time segment
    // ----------------------------------------------------------------
    sends = 0;
    // Single axis, asynchronous: no sync messages to start first
    wreg(OFF_CTRL, 32'h00000014);
    settle;
    check(run, 1'b1);
    check(s_head, 24'h00aa05);
    check(s_tail, 24'h00cc05);
    en <= 1'b1;
    for (n = 0; n < 200 && mdones == 0; n++) @(posedge sys_clk_i);
    guard(n);
    repeat (3) @(posedge sys_clk_i);
    en <= 1'b0;
    #1;
    check(mdones, 1);
    check(sends, 3);
    check(status, 32'h00200003);
    check(stops, 0);
    // ----------------------------------------------------------------
    // Control word aborts stop at once, mid segment
    // ----------------------------------------------------------------
    foreach (ab[i]) begin
      fresh;
      wreg(OFF_SEG, 32'h00110500);
      wreg(OFF_SEG, 32'h00220501);
      wreg(OFF_CTRL, 32'h00000014);
      wreg(OFF_CTRL, ab[i]);
      settle;
      check(stop, 1'b1);
      check(run, 1'b0);
    end
    // ----------------------------------------------------------------
    // Buffer runs dry mid-move: underflow and abort
    // ----------------------------------------------------------------
    fresh;
    wreg(OFF_SEG, 32'h00110500);
    wreg(OFF_SEG, 32'h00220501);
    stops = 0;
    wreg(OFF_CTRL, 32'h00000014);
    en <= 1'b1;
    for (n = 0; n < 200 && stops == 0; n++) @(posedge sys_clk_i);
    guard(n);
    en <= 1'b0;
    settle;
    check(status & 32'h04000000, 32'h04000000);
    check(run, 1'b0);
    // ----------------------------------------------------------------
    // One segment past capacity is dropped and flags overflow
    // ----------------------------------------------------------------
    fresh;
    for (n = 0; n < 33; n++) wreg(OFF_SEG, {21'h0005, n[2:0]} << 8 | n[2:0]);
    settle;
    check(status & 32'h03ffffff, 32'h02000020);
    close_out;
  end
endmodule
